// >>> rsq_pkg.sv
// Shared constants and types for the reset output and soft reset sequencer
package rsq_pkg;
  localparam int CLK_HZ = 100_000_000;
  // Reset delay, filter and long open window figures in microseconds
  localparam int RESET_DELAY_US = 10_000;
  localparam int RESET_FILTER_US = 10;
  localparam int LONG_WINDOW_US = 200_000;
  localparam int RESET_DELAY_CYC = (RESET_DELAY_US * (CLK_HZ / 1_000_000));
  localparam int RESET_FILTER_CYC = (RESET_FILTER_US * (CLK_HZ / 1_000_000));
  localparam int LONG_WINDOW_CYC = (LONG_WINDOW_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W = 25;
  // Operating mode field encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
  // Undervoltage threshold select reset value (default falling threshold)
  localparam logic [1:0] UV_SEL_DEFAULT = 2'h0;
  localparam logic SOFT_RST_PIN_DEFAULT = 1'h0;
  localparam logic [1:0] WATCHDOG_FAIL_COUNT_MAX = 2'h2;
  localparam logic [1:0] WATCHDOG_FAIL_COUNT_ONE = 2'h1;

  typedef enum logic [5:0] {
    RSQ_INIT = 6'h01,
    RSQ_NORMAL = 6'h02,
    RSQ_STOP = 6'h04,
    RSQ_SLEEP = 6'h08,
    RSQ_RESTART = 6'h10,
    RSQ_FAILSAFE = 6'h20
  } rsq_mode_t;
endpackage

// >>> rsq_timer.sv
// Reloadable down counter used for filter and delay intervals
`timescale 1ns/100ps
module rsq_timer #(
  parameter int WIDTH = 25
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_value,
  input wire logic i_run,
  // Status
  output logic o_done
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } rsq_timer_state_t;

  rsq_timer_state_t state;
  rsq_timer_state_t next_state;

  always_comb begin
    next_state = state;
    if (i_load) begin
      next_state.count = i_value;
    end else if (i_run && state.count != '0) begin
      next_state.count = state.count - WIDTH'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_done = (state.count == '0) && !i_load;
endmodule // rsq_timer

// >>> rsq_reset_seq.sv
// Reset output sequencer with soft reset handling
`timescale 1ns/100ps
// Overview of operation
// - Reset out goes low when the regulator stays under the chosen threshold past the filter.
// - Reset out stays low while a cause persists and one more reset delay after it ends.
// - After power on reset out starts low until the regulator reaches the rising threshold.
// - After the rising threshold is reached, reset out releases only after the reset delay.
// - A watchdog failure drives reset out low just like an undervoltage.
// - The undervoltage threshold select is configurable and resets to the default falling one.
// - A taken soft reset returns to init mode, unless a watchdog failure in the same cycle sets restart or fail safe, and restores every setting to default.
// - A soft reset request outside normal or stop mode is ignored.
// - With the pin option at default a soft reset pulses reset out low with the reset delay.
// - With the pin option set, a soft reset leaves reset out high.
// - A watchdog reset enters restart or fail safe per config and bumps the failure count, which saturates at two.
// - On release after a watchdog reset the watchdog gets a long window and normal mode starts.
module rsq_reset_seq #(
  parameter int RESET_DELAY_CYC = rsq_pkg::RESET_DELAY_CYC,
  parameter int LONG_WINDOW_CYC = rsq_pkg::LONG_WINDOW_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Supply comparators, one per selectable falling threshold, plus the rising one
  input wire logic [3:0] i_main_regulator_under,
  input wire logic i_main_regulator_above_rising,
  // Watchdog and mode request
  input wire logic i_watchdog_fail_count,
  input wire logic i_watchdog_fail_count_to_failsafe,
  input wire logic i_wd_cleared,
  input wire logic i_mode_write,
  input wire logic [1:0] i_mode_value,
  // Configuration writes
  input wire logic i_cfg_write,
  input wire logic [1:0] i_cfg_uv_sel,
  input wire logic i_cfg_soft_rst_drives_pin,
  // Outputs
  output logic o_reset_out_n,
  output logic [5:0] o_mode,
  output logic [1:0] o_uv_sel,
  output logic o_soft_rst_drives_pin,
  output logic [1:0] o_watchdog_fail_count,
  output logic o_wd_long_window,
  output logic o_soft_reset_pulse
);
  typedef struct packed {
    rsq_pkg::rsq_mode_t mode;
    logic reset_low;
    logic powered;
    logic wd_pending;
    logic [1:0] uv_sel;
    logic soft_rst_drives_pin;
    logic [1:0] watchdog_fail_count_count;
    logic long_window;
    logic soft_pulse;
    logic [rsq_pkg::CNT_W-1:0] window_cnt;
  } rsq_state_t;

  rsq_state_t state;
  rsq_state_t next_state;
  logic uv_now;
  logic uv_qualified;
  logic soft_ok;
  logic cause;
  logic delay_load;
  logic delay_done;

  assign uv_now = i_main_regulator_under[state.uv_sel];
  assign soft_ok = i_mode_write && (i_mode_value == rsq_pkg::MODE_SOFT_RESET)
                   && (state.mode == rsq_pkg::RSQ_NORMAL || state.mode == rsq_pkg::RSQ_STOP);

  rsq_timer #(
    .WIDTH(rsq_pkg::CNT_W)
  ) u_filter (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_load(!uv_now),
    .i_value(rsq_pkg::CNT_W'(rsq_pkg::RESET_FILTER_CYC)),
    .i_run(uv_now),
    .o_done(uv_qualified)
  );

  assign cause = (uv_now && uv_qualified) || i_watchdog_fail_count || !state.powered
                 || (soft_ok && !state.soft_rst_drives_pin);
  assign delay_load = cause;

  rsq_timer #(
    .WIDTH(rsq_pkg::CNT_W)
  ) u_delay (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_load(delay_load),
    .i_value(rsq_pkg::CNT_W'(RESET_DELAY_CYC)),
    .i_run(state.reset_low),
    .o_done(delay_done)
  );

  always_comb begin
    next_state = state;
    next_state.soft_pulse = 1'b0;
    if (!state.powered && i_main_regulator_above_rising) begin
      next_state.powered = 1'b1;
    end
    if (i_cfg_write) begin
      next_state.uv_sel = i_cfg_uv_sel;
      next_state.soft_rst_drives_pin = i_cfg_soft_rst_drives_pin;
    end
    if (i_mode_write && !soft_ok) begin
      case (i_mode_value)
        rsq_pkg::MODE_NORMAL: next_state.mode = rsq_pkg::RSQ_NORMAL;
        rsq_pkg::MODE_SLEEP: next_state.mode = rsq_pkg::RSQ_SLEEP;
        rsq_pkg::MODE_STOP: next_state.mode = rsq_pkg::RSQ_STOP;
        default: next_state.mode = state.mode;
      endcase
    end
    if (i_wd_cleared) begin
      next_state.watchdog_fail_count_count = 2'h0;
    end
    if (soft_ok) begin
      next_state.mode = rsq_pkg::RSQ_INIT;
      next_state.uv_sel = rsq_pkg::UV_SEL_DEFAULT;
      next_state.soft_rst_drives_pin = rsq_pkg::SOFT_RST_PIN_DEFAULT;
      next_state.watchdog_fail_count_count = 2'h0;
      next_state.wd_pending = 1'b0;
      next_state.soft_pulse = 1'b1;
      if (!state.soft_rst_drives_pin) begin
        next_state.reset_low = 1'b1;
      end
    end
    // Watchdog failure comes after the soft reset so a failure in the same cycle is never lost
    // watchdog drives reset
    if (i_watchdog_fail_count) begin
      next_state.reset_low = 1'b1;
      next_state.wd_pending = 1'b1;
      next_state.mode = i_watchdog_fail_count_to_failsafe ? rsq_pkg::RSQ_FAILSAFE : rsq_pkg::RSQ_RESTART;
      if (state.watchdog_fail_count_count != rsq_pkg::WATCHDOG_FAIL_COUNT_MAX) begin
        next_state.watchdog_fail_count_count = state.watchdog_fail_count_count + rsq_pkg::WATCHDOG_FAIL_COUNT_ONE;
      end
    end
    if (uv_now && uv_qualified) begin
      next_state.reset_low = 1'b1;
    end
    if (state.reset_low && !cause && delay_done && state.powered) begin
      next_state.reset_low = 1'b0;
      next_state.long_window = 1'b1;
      next_state.window_cnt = rsq_pkg::CNT_W'(LONG_WINDOW_CYC);
      if (state.wd_pending) begin
        next_state.mode = rsq_pkg::RSQ_NORMAL;
        next_state.wd_pending = 1'b0;
      end
    end else if (state.long_window) begin
      if (state.window_cnt == '0 || i_wd_cleared) begin
        next_state.long_window = 1'b0;
      end else begin
        next_state.window_cnt = state.window_cnt - rsq_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state <= '{
        mode: rsq_pkg::RSQ_INIT,
        reset_low: 1'b1,
        powered: 1'b0,
        wd_pending: 1'b0,
        uv_sel: rsq_pkg::UV_SEL_DEFAULT,
        soft_rst_drives_pin: rsq_pkg::SOFT_RST_PIN_DEFAULT,
        watchdog_fail_count_count: 2'h0,
        long_window: 1'b0,
        soft_pulse: 1'b0,
        window_cnt: '0
      };
    end else begin
      state <= next_state;
    end
  end

  assign o_reset_out_n = !state.reset_low;
  assign o_mode = state.mode;
  assign o_uv_sel = state.uv_sel;
  assign o_soft_rst_drives_pin = state.soft_rst_drives_pin;
  assign o_watchdog_fail_count = state.watchdog_fail_count_count;
  assign o_wd_long_window = state.long_window;
  assign o_soft_reset_pulse = state.soft_pulse;
endmodule // rsq_reset_seq

// >>> rsq_props.sv
// Port assertions for the reset sequencer
`timescale 1ns/100ps
module rsq_props (
  // Clock, reset and causes
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_main_regulator_above_rising,
  input wire logic i_watchdog_fail_count,
  input wire logic i_watchdog_fail_count_to_failsafe,
  input wire logic i_wd_cleared,
  input wire logic i_mode_write,
  input wire logic [1:0] i_mode_value,
  // Watched outputs
  input wire logic o_reset_out_n,
  input wire logic [5:0] o_mode,
  input wire logic [1:0] o_uv_sel,
  input wire logic o_soft_rst_drives_pin,
  input wire logic [1:0] o_watchdog_fail_count,
  input wire logic o_soft_reset_pulse
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic sr = i_mode_write && i_mode_value == 2'h3 && !i_watchdog_fail_count;
  wire logic act = o_mode == 6'h02 || o_mode == 6'h04;
  a_wd_low: assert property (i_watchdog_fail_count |=> !o_reset_out_n)
    else $error("watchdog fail left reset high");
  a_wd_restart: assert property (i_watchdog_fail_count && !i_watchdog_fail_count_to_failsafe |=> o_mode == 6'h10)
    else $error("restart mode not entered");
  a_wd_failsafe: assert property (i_watchdog_fail_count && i_watchdog_fail_count_to_failsafe |=> o_mode == 6'h20)
    else $error("fail safe mode not entered");
  a_fail_count: assert property (i_watchdog_fail_count && !i_wd_cleared && o_watchdog_fail_count != 2'h2
    |=> o_watchdog_fail_count == $past(o_watchdog_fail_count) + 2'h1)
    else $error("fail count not bumped");
  a_sr_take: assert property (sr && act
    |=> o_soft_reset_pulse && o_mode == 6'h01 && o_uv_sel == 2'h0)
    else $error("soft reset not taken");
  a_sr_ignore: assert property (sr && !act |=> !o_soft_reset_pulse)
    else $error("soft reset taken outside normal or stop");
  a_sr_pin_low: assert property (sr && act && !o_soft_rst_drives_pin |=> !o_reset_out_n)
    else $error("soft reset did not pull reset low");
  a_sr_pin_high: assert property (sr && act && o_soft_rst_drives_pin && o_reset_out_n
    |=> o_reset_out_n)
    else $error("soft reset moved reset pin");
  a_unpowered: assert property (!o_reset_out_n && !i_main_regulator_above_rising
    |=> !o_reset_out_n)
    else $error("reset released while unpowered");
  a_uv_default: assert property ($rose(i_reset_n) |-> o_uv_sel == 2'h0)
    else $error("threshold select not default");
  cover property (sr && act);
  cover property (i_watchdog_fail_count);
  cover property ($rose(o_reset_out_n));
endmodule // rsq_props

bind rsq_reset_seq rsq_props rsq_props_i (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_main_regulator_above_rising(i_main_regulator_above_rising),
  .i_watchdog_fail_count(i_watchdog_fail_count),
  .i_watchdog_fail_count_to_failsafe(i_watchdog_fail_count_to_failsafe),
  .i_wd_cleared(i_wd_cleared),
  .i_mode_write(i_mode_write),
  .i_mode_value(i_mode_value),
  .o_reset_out_n(o_reset_out_n),
  .o_mode(o_mode),
  .o_uv_sel(o_uv_sel),
  .o_soft_rst_drives_pin(o_soft_rst_drives_pin),
  .o_watchdog_fail_count(o_watchdog_fail_count),
  .o_soft_reset_pulse(o_soft_reset_pulse)
);

// >>> rsq_mcu.sv
// Controller model that writes the operating mode field
`timescale 1ns/100ps
module rsq_mcu (
  // Clock
  input wire logic i_clk,
  // Mode field write
  output logic o_mode_write,
  output logic [1:0] o_mode_value
);
  initial begin
    o_mode_write = 1'h0;
    o_mode_value = 2'h0;
  end
  // mode field write request
  // An edge passes first so back to back calls never lower and raise the strobe at once
  task automatic send(input logic [1:0] v);
    @(posedge i_clk);
    #1;
    o_mode_write = 1'h1;
    o_mode_value = v;
    @(posedge i_clk);
    #1;
    o_mode_write = 1'h0;
    // Released field shows a changed value, not the stale one
    o_mode_value = ~v;
  endtask
endmodule // rsq_mcu

// >>> rsq_reset_seq_tb.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
module rsq_reset_seq_tb;
  logic clk, rst_n, above, wd, fs, clr;
  logic cw, pin, mw, out_n, opin, sp, lw;
  logic [3:0] under;
  logic [1:0] sel, mval, usel, cnt;
  logic [5:0] mode;
  int err_count = 0, checked = 0, n;
  always #5 clk = ~clk;
  rsq_mcu rsq_mcu_i (.i_clk(clk), .o_mode_write(mw), .o_mode_value(mval));
  rsq_reset_seq #(.RESET_DELAY_CYC(20), .LONG_WINDOW_CYC(50)) rsq_reset_seq_i (
    .i_clk(clk), .i_reset_n(rst_n), .i_main_regulator_under(under),
    .i_main_regulator_above_rising(above), .i_watchdog_fail_count(wd), .i_watchdog_fail_count_to_failsafe(fs),
    .i_wd_cleared(clr), .i_mode_write(mw), .i_mode_value(mval), .i_cfg_write(cw),
    .i_cfg_uv_sel(sel), .i_cfg_soft_rst_drives_pin(pin), .o_reset_out_n(out_n),
    .o_mode(mode), .o_uv_sel(usel), .o_soft_rst_drives_pin(opin),
    .o_watchdog_fail_count(cnt), .o_wd_long_window(lw), .o_soft_reset_pulse(sp));
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Cycles until release land in n; a hang ends the run
  task automatic rel();
    n = 0;
    while (out_n !== 1'h1 && n < 300) begin
      step(1);
      n++;
    end
    if (n == 300) begin
      chk(0, "no release");
      final_report();
    end
  endtask
  task automatic pulse_wd();
    wd = 1'h1;
    step(1);
    wd = 1'h0;
  endtask
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    above = 1'h0;
    wd = 1'h0;
    fs = 1'h0;
    clr = 1'h0;
    cw = 1'h0;
    pin = 1'h0;
    under = 4'h0;
    sel = 2'h0;
    step(2);
    rst_n = 1'h1;
    step(5);
    chk(out_n === 1'h0, "released unpowered");
    above = 1'h1;
    rel();
    chk(n >= 20, "power up delay short");
    rsq_mcu_i.send(2'h0);
    under = 4'h1;
    step(990);
    chk(out_n === 1'h1, "filter too short");
    step(20);
    chk(out_n === 1'h0, "undervoltage missed");
    step(40);
    chk(out_n === 1'h0, "released during cause");
    under = 4'h0;
    rel();
    chk(n >= 20, "hold delay short");
    cw = 1'h1;
    sel = 2'h2;
    pin = 1'h1;
    step(1);
    cw = 1'h0;
    chk(usel === 2'h2 && opin === 1'h1, "config not taken");
    rsq_mcu_i.send(2'h2);
    rsq_mcu_i.send(2'h3);
    chk(mode === 6'h01 && usel === 2'h0 && opin === 1'h0 && sp === 1'h1, "defaults");
    chk(out_n === 1'h1, "pin moved");
    rsq_mcu_i.send(2'h3);
    chk(mode === 6'h01 && sp === 1'h0, "taken in init");
    rsq_mcu_i.send(2'h0);
    rsq_mcu_i.send(2'h3);
    chk(out_n === 1'h0, "no soft pulse");
    rel();
    chk(n >= 18, "soft delay short");
    rsq_mcu_i.send(2'h0);
    pulse_wd();
    chk(out_n === 1'h0 && mode === 6'h10 && cnt === 2'h1, "watchdog restart");
    rel();
    step(1);
    chk(mode === 6'h02 && lw === 1'h1, "watchdog release");
    fs = 1'h1;
    pulse_wd();
    step(1);
    pulse_wd();
    chk(mode === 6'h20 && cnt === 2'h2, "fail safe count");
    clr = 1'h1;
    step(1);
    clr = 1'h0;
    chk(cnt === 2'h0 && lw === 1'h0, "count not cleared");
    cw = 1'h1;
    sel = 2'h1;
    step(1);
    cw = 1'h0;
    rst_n = 1'h0;
    step(2);
    rst_n = 1'h1;
    chk(out_n === 1'h0 && mode === 6'h01 && usel === 2'h0, "reset defaults");
    rel();
    chk(n >= 20, "restart delay short");
    final_report();
  end
endmodule // rsq_reset_seq_tb
